// >>> hw/sensor_drive_reset_regs.sv
`include "drive_regs_map.svh"

module sensor_drive_reset_regs #(
  parameter bit FOUR_CHANNEL = 1'b1
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Register access
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_wdata,
  output      logic [15:0] o_reg_rdata,
  // Configuration bits
  input  wire logic        i_manual_drive_select,
  input  wire logic        i_amplitude_tracking_off,
  // Conversion engine
  input  wire logic [1:0]  i_conv_chan,
  input  wire logic [3:0]  i_cal_strobe,
  input  wire logic [4:0]  i_cal_value,
  input  wire logic [15:0] i_raw_data,
  output      logic [4:0]  o_applied_drive,
  output      logic        o_drive_from_reg,
  output      logic [15:0] o_gain_data,
  // Device reset request
  output      logic        o_soft_reset
);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  drive_regs_pkg::gain_code_t  gain_ff;
  drive_regs_pkg::gain_code_t  nxt_gain;
  logic                        soft_rst_ff;
  logic                        nxt_soft_rst;
  logic                        ctl_hit;
  logic [`DRV_CHANNELS-1:0]    chan_hit;
  logic [`DRV_CHANNELS-1:0]    chan_present;

  assign ctl_hit = (i_reg_addr == `DRV_ADDR_RST_GAIN);

  always_comb begin
    nxt_gain     = gain_ff;
    nxt_soft_rst = 1'b0;
    if (soft_rst_ff) begin
      nxt_gain = drive_regs_pkg::gain_code_t'(`DRV_GAIN_RST);
    end else if (i_reg_wr && ctl_hit) begin
      nxt_gain = drive_regs_pkg::gain_code_t'(i_reg_wdata[`DRV_GAIN_HI:`DRV_GAIN_LO]);
      nxt_soft_rst = i_reg_wdata[`DRV_SOFT_RST_BIT];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      gain_ff     <= drive_regs_pkg::gain_code_t'(`DRV_GAIN_RST);
      soft_rst_ff <= 1'b0;
    end else begin
      gain_ff     <= nxt_gain;
      soft_rst_ff <= nxt_soft_rst;
    end
  end

  assign o_soft_reset = soft_rst_ff;

  // ----------------------------------------
  // Channel registers
  // ----------------------------------------
  drive_chan_if u_chan_if [`DRV_CHANNELS] ();
  logic [4:0] prog_q [`DRV_CHANNELS];
  logic [4:0] cal_q  [`DRV_CHANNELS];

  genvar gi;
  generate
    for (gi = 0; gi < `DRV_CHANNELS; gi++) begin : g_chan
      assign chan_present[gi] = (gi < 2) || FOUR_CHANNEL;
      assign chan_hit[gi]     = chan_present[gi] &&
                                (i_reg_addr == 8'(`DRV_ADDR_CH0 + gi));
      assign u_chan_if[gi].clr        = soft_rst_ff;
      assign u_chan_if[gi].wr         = i_reg_wr && chan_hit[gi];
      assign u_chan_if[gi].wr_prog    = i_reg_wdata[`DRV_PROG_HI:`DRV_PROG_LO];
      assign u_chan_if[gi].cal_strobe = i_cal_strobe[gi] && chan_present[gi];
      assign u_chan_if[gi].cal_value  = i_cal_value;
      assign u_chan_if[gi].amp_off    = i_amplitude_tracking_off;
      assign prog_q[gi]               = u_chan_if[gi].prog_q;
      assign cal_q[gi]                = u_chan_if[gi].cal_q;

      drive_channel_reg u_chan (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .ch         (u_chan_if[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;

  always_comb begin
    nxt_rdata = rdata_ff;
    if (i_reg_rd) begin
      nxt_rdata = `DRV_DATA_RST;
      if (ctl_hit) begin
        nxt_rdata[`DRV_GAIN_HI:`DRV_GAIN_LO] = gain_ff;
      end
      for (int i = 0; i < `DRV_CHANNELS; i++) begin
        if (chan_hit[i]) begin
          nxt_rdata = {prog_q[i], cal_q[i], {`DRV_LOW_RSVD_W{1'b0}}};
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_ff <= `DRV_DATA_RST;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_reg_rdata = rdata_ff;

  // ----------------------------------------
  // Drive selection and output gain
  // ----------------------------------------
  logic [4:0]  drive_ff;
  logic [4:0]  nxt_drive;
  logic        from_reg_ff;
  logic        nxt_from_reg;
  logic [15:0] gain_data_ff;
  logic [15:0] nxt_gain_data;

  always_comb begin
    nxt_from_reg = i_manual_drive_select;
    nxt_drive    = i_manual_drive_select ? prog_q[i_conv_chan] : cal_q[i_conv_chan];
    case (gain_ff)
      drive_regs_pkg::GAIN_X1:  nxt_gain_data = i_raw_data;
      drive_regs_pkg::GAIN_X4:  nxt_gain_data = 16'(i_raw_data << 2);
      drive_regs_pkg::GAIN_X8:  nxt_gain_data = 16'(i_raw_data << 3);
      drive_regs_pkg::GAIN_X16: nxt_gain_data = 16'(i_raw_data << 4);
      default:                  nxt_gain_data = i_raw_data;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      drive_ff     <= `DRV_FIELD_RST;
      from_reg_ff  <= 1'b0;
      gain_data_ff <= `DRV_DATA_RST;
    end else begin
      drive_ff     <= nxt_drive;
      from_reg_ff  <= nxt_from_reg;
      gain_data_ff <= nxt_gain_data;
    end
  end

  assign o_applied_drive  = drive_ff;
  assign o_drive_from_reg = from_reg_ff;
  assign o_gain_data      = gain_data_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  soft_reset_pulse_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_reg_wr && ctl_hit && i_reg_wdata[15] && !soft_rst_ff) |=> o_soft_reset ##1 !o_soft_reset)
    else $error("soft reset pulse wrong");

  reset_bit_zero_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_reg_rd && ctl_hit) |=> (o_reg_rdata[15] == 1'b0))
    else $error("reset bit read as one");

  gain_shift_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    1'b1 |=> (o_gain_data == 16'($past(i_raw_data) <<
      (($past(gain_ff) == drive_regs_pkg::GAIN_X1) ? 0 : $past(gain_ff) + 1))))
    else $error("gain shift wrong");

  prog_drive_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_manual_drive_select && !soft_rst_ff && !i_reg_wr) |=>
      (o_applied_drive == prog_q[$past(i_conv_chan)]) && o_drive_from_reg)
    else $error("programmed drive not applied");

  cal_drive_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (!i_manual_drive_select && i_cal_strobe == 4'h0 && !soft_rst_ff) |=>
      (o_applied_drive == cal_q[$past(i_conv_chan)]) && !o_drive_from_reg)
    else $error("calibrated drive not applied");

  absent_chan_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_reg_rd && !FOUR_CHANNEL && (i_reg_addr == 8'h20 || i_reg_addr == 8'h21)) |=>
      (o_reg_rdata == 16'h0000))
    else $error("absent channel register read nonzero");

  soft_clear_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    soft_rst_ff |=> (gain_ff == drive_regs_pkg::GAIN_X1) && (prog_q[0] == 5'h00) &&
      (prog_q[3] == 5'h00))
    else $error("soft reset left state");

  prog_write_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_reg_wr && chan_hit[1] && !soft_rst_ff) |=> (prog_q[1] == $past(i_reg_wdata[15:11])))
    else $error("programmed drive not stored");

  cov_soft_reset: cover property (@(posedge i_core_clk) disable iff (i_rst) o_soft_reset);
  cov_gain_x16: cover property (@(posedge i_core_clk) disable iff (i_rst)
    gain_ff == drive_regs_pkg::GAIN_X16);
  cov_override: cover property (@(posedge i_core_clk) disable iff (i_rst)
    o_drive_from_reg && o_applied_drive != 5'h00);

endmodule

// >>> hw/drive_regs_map.svh
`ifndef DRIVE_REGS_MAP_SVH
`define DRIVE_REGS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DRV_ADDR_RST_GAIN   8'h1c
`define DRV_ADDR_CH0        8'h1e
`define DRV_ADDR_CH1        8'h1f
`define DRV_ADDR_CH2        8'h20
`define DRV_ADDR_CH3        8'h21

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DRV_SOFT_RST_BIT    15
`define DRV_GAIN_HI         10
`define DRV_GAIN_LO         9
`define DRV_PROG_HI         15
`define DRV_PROG_LO         11
`define DRV_CAL_HI          10
`define DRV_CAL_LO          6
`define DRV_LOW_RSVD_W      6

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define DRV_GAIN_RST        2'h0
`define DRV_FIELD_RST       5'h00
`define DRV_DATA_RST        16'h0000
`define DRV_CHANNELS        4

`endif

// >>> hw/drive_regs_pkg.sv
package drive_regs_pkg;

  // Output gain codes, in register encoding order
  typedef enum logic [1:0] {
    GAIN_X1,
    GAIN_X4,
    GAIN_X8,
    GAIN_X16
  } gain_code_t;

  typedef logic [4:0]  drive_code_t;
  typedef logic [15:0] reg_word_t;

endpackage

// >>> hw/drive_chan_if.sv
interface drive_chan_if;
  logic                       clr;
  logic                       wr;
  drive_regs_pkg::drive_code_t wr_prog;
  logic                       cal_strobe;
  drive_regs_pkg::drive_code_t cal_value;
  logic                       amp_off;
  drive_regs_pkg::drive_code_t prog_q;
  drive_regs_pkg::drive_code_t cal_q;

  modport bank (output clr, wr, wr_prog, cal_strobe, cal_value, amp_off,
                input  prog_q, cal_q);
  modport chan (input  clr, wr, wr_prog, cal_strobe, cal_value, amp_off,
                output prog_q, cal_q);
endinterface

// >>> hw/drive_channel_reg.sv
`include "drive_regs_map.svh"

module drive_channel_reg (
  // Clock and reset
  input  wire logic   i_core_clk,
  input  wire logic   i_rst,
  // Bank side
  drive_chan_if.chan  ch
);

  drive_regs_pkg::drive_code_t prog_ff;
  drive_regs_pkg::drive_code_t nxt_prog;
  drive_regs_pkg::drive_code_t cal_ff;
  drive_regs_pkg::drive_code_t nxt_cal;

  always_comb begin
    nxt_prog = prog_ff;
    nxt_cal  = cal_ff;
    if (ch.clr) begin
      nxt_prog = `DRV_FIELD_RST;
      nxt_cal  = `DRV_FIELD_RST;
    end else begin
      if (ch.wr) begin
        nxt_prog = ch.wr_prog;
      end
      if (ch.cal_strobe && !ch.amp_off) begin
        nxt_cal = ch.cal_value;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      prog_ff <= `DRV_FIELD_RST;
      cal_ff  <= `DRV_FIELD_RST;
    end else begin
      prog_ff <= nxt_prog;
      cal_ff  <= nxt_cal;
    end
  end

  assign ch.prog_q = prog_ff;
  assign ch.cal_q  = cal_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  cal_refresh_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (ch.cal_strobe && !ch.amp_off && !ch.clr) |=> (cal_ff == $past(ch.cal_value)))
    else $error("calibrated drive not refreshed");

  cal_frozen_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (ch.amp_off && !ch.clr) |=> $stable(cal_ff))
    else $error("calibrated drive moved while tracking off");

  cal_readonly_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (ch.wr && !ch.cal_strobe && !ch.clr) |=> $stable(cal_ff))
    else $error("host write altered calibrated drive");

endmodule

// >>> verif/sensor_drive_reset_regs_tb.sv
`include "drive_regs_map.svh"

module sensor_drive_reset_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic                            i_core_clk;
  logic                            i_rst;
  logic [7:0]                      i_reg_addr;
  logic                            i_reg_wr;
  logic                            i_reg_rd;
  logic [15:0]                     i_reg_wdata;
  logic [15:0]                     o_reg_rdata;
  logic                            i_manual_drive_select;
  logic                            i_amplitude_tracking_off;
  logic [1:0]                      i_conv_chan;
  logic [3:0]                      i_cal_strobe;
  logic [4:0]                      i_cal_value;
  logic [15:0]                     i_raw_data;
  logic [4:0]                      o_applied_drive;
  logic                            o_drive_from_reg;
  logic [15:0]                     o_gain_data;
  logic                            o_soft_reset;
  logic [15:0]                     rdata_two;
  drive_regs_pkg::drive_code_t     prog [4];
  drive_regs_pkg::drive_code_t     cal [4];
  drive_regs_pkg::reg_word_t       raw;
  int                              fails;
  int                              n_checks;
  int                              cycles;
  int                              pulses;

  sensor_drive_reset_regs #(.FOUR_CHANNEL(1'b1)) u_dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_manual_drive_select(i_manual_drive_select),
    .i_amplitude_tracking_off(i_amplitude_tracking_off), .i_conv_chan(i_conv_chan),
    .i_cal_strobe(i_cal_strobe), .i_cal_value(i_cal_value), .i_raw_data(i_raw_data),
    .o_applied_drive(o_applied_drive), .o_drive_from_reg(o_drive_from_reg),
    .o_gain_data(o_gain_data), .o_soft_reset(o_soft_reset)
  );

  // Two-channel variant on the same stimulus
  sensor_drive_reset_regs #(.FOUR_CHANNEL(1'b0)) u_dut_two_ch (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(rdata_two), .i_manual_drive_select(i_manual_drive_select),
    .i_amplitude_tracking_off(i_amplitude_tracking_off), .i_conv_chan(i_conv_chan),
    .i_cal_strobe(i_cal_strobe), .i_cal_value(i_cal_value), .i_raw_data(i_raw_data),
    .o_applied_drive(), .o_drive_from_reg(), .o_gain_data(), .o_soft_reset()
  );

  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  // ----------------------------------------
  // Expectations and checks
  // ----------------------------------------
  function automatic drive_regs_pkg::reg_word_t exp_drive(input int k);
    return {prog[k], cal[k], 6'h00};
  endfunction

  function automatic drive_regs_pkg::reg_word_t exp_gain(input logic [15:0] r,
                                                         input logic [1:0] g);
    case (g)
      2'h0: return r;
      2'h1: return r << 2;
      2'h2: return r << 3;
      default: return r << 4;
    endcase
  endfunction

  task automatic note(input bit bad, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (bad) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input drive_regs_pkg::reg_word_t got, exp);
    note(got !== exp, got, exp);
  endtask

  task automatic chk_code(input drive_regs_pkg::drive_code_t got, exp);
    note(got !== exp, {11'h000, got}, {11'h000, exp});
  endtask

  task automatic chk_bit(input logic got, exp);
    note(got !== exp, {15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic give_verdict();
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Register port tasks
  // ----------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    i_reg_wr    = 1'b1;
    i_reg_addr  = a;
    i_reg_wdata = d;
    @(negedge i_core_clk);
    i_reg_wr    = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(negedge i_core_clk);
    i_reg_rd   = 1'b1;
    i_reg_addr = a;
    @(negedge i_core_clk);
    i_reg_rd   = 1'b0;
    chk_word(o_reg_rdata, exp);
  endtask

  task automatic rd_drive(input int k);
    rd_chk(8'(`DRV_ADDR_CH0 + k), exp_drive(k));
    chk_word(rdata_two, (k < 2) ? exp_drive(k) : `DRV_DATA_RST);
  endtask

  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {i_reg_addr, i_reg_wr, i_reg_rd, i_reg_wdata, i_conv_chan, i_cal_strobe} = '0;
    {i_manual_drive_select, i_amplitude_tracking_off, i_cal_value, i_raw_data} = '0;
    fails = 0;
    n_checks = 0;
    cycles = 0;
    i_rst = 1'b1;
    void'($urandom(65117));
    for (int k = 0; k < 4; k++) begin
      prog[k] = 5'h00;
      cal[k]  = 5'h00;
    end
    repeat (12) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_rst = 1'b0;
    for (int a = 8'h1c; a <= 8'h21; a++) rd_chk(8'(a), 16'h0000);
    // Programmed drive, zeros in calibrated and reserved bits
    for (int k = 0; k < 4; k++) begin
      prog[k] = 5'($urandom);
      wr_reg(8'(`DRV_ADDR_CH0 + k), {prog[k], 5'h00, 6'h00});
    end
    wr_reg(8'h1d, 16'hffff);
    rd_chk(8'h1d, 16'h0000);
    for (int k = 0; k < 4; k++) rd_drive(k);
    // Calibration refresh, then frozen while tracking is off
    for (int k = 0; k < 4; k++) begin
      @(negedge i_core_clk);
      cal[k] = 5'($urandom);
      i_cal_strobe = 4'(1 << k);
      i_cal_value = cal[k];
    end
    @(negedge i_core_clk);
    i_amplitude_tracking_off = 1'b1;
    i_cal_strobe = 4'hf;
    i_cal_value = ~cal[0];
    @(negedge i_core_clk);
    i_cal_strobe = 4'h0;
    for (int k = 0; k < 4; k++) rd_drive(k);
    // Host rewrite leaves calibrated field alone
    for (int k = 0; k < 4; k++) begin
      prog[k] = 5'($urandom);
      wr_reg(8'(`DRV_ADDR_CH0 + k), {prog[k], 5'h00, 6'h00});
      rd_drive(k);
    end
    // Applied drive per channel, override on and off
    for (int m = 1; m >= 0; m--) begin
      for (int k = 0; k < 4; k++) begin
        @(negedge i_core_clk);
        i_manual_drive_select = 1'(m);
        i_conv_chan = 2'(k);
        @(negedge i_core_clk);
        chk_bit(o_drive_from_reg, 1'(m));
        if (m == 1) chk_code(o_applied_drive, prog[k]);
        else chk_code(o_applied_drive, cal[k]);
      end
    end
    // Every gain code, with an all-ones corner value
    for (int g = 0; g < 4; g++) begin
      wr_reg(`DRV_ADDR_RST_GAIN, {5'h00, 2'(g), 9'h000});
      rd_chk(`DRV_ADDR_RST_GAIN, {5'h00, 2'(g), 9'h000});
      for (int n = 0; n < 3; n++) begin
        raw = (n == 0) ? 16'hffff : 16'($urandom);
        @(negedge i_core_clk);
        i_raw_data = raw;
        @(negedge i_core_clk);
        chk_word(o_gain_data, exp_gain(raw, 2'(g)));
      end
    end
    // Soft reset command together with a gain code
    @(negedge i_core_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = `DRV_ADDR_RST_GAIN;
    i_reg_wdata = 16'h8600;
    pulses = 0;
    for (int n = 0; n < 4; n++) begin
      @(negedge i_core_clk);
      i_reg_wr = 1'b0;
      if (o_soft_reset === 1'b1) pulses++;
    end
    chk_word(16'(pulses), 16'h0001);
    for (int k = 0; k < 4; k++) begin
      prog[k] = 5'h00;
      cal[k]  = 5'h00;
    end
    rd_chk(`DRV_ADDR_RST_GAIN, 16'h0000);
    for (int k = 0; k < 4; k++) rd_drive(k);
    @(negedge i_core_clk);
    i_raw_data = 16'h1234;
    @(negedge i_core_clk);
    chk_word(o_gain_data, 16'h1234);
    give_verdict();
  end
endmodule
